// [design/accel_cfg_pkg.sv]
// Constants for the motion-detect configuration register bank.
// Assumes a serial front end that turns I2C or SPI frames into byte register accesses.
package accel_cfg_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_DETECT_SOURCE = 8'h0a;
  localparam logic [7:0] ADDR_Z_OFFSET_LOW  = 8'h14;
  localparam logic [7:0] ADDR_Z_OFFSET_HIGH = 8'h15;
  localparam logic [7:0] ADDR_MODE_CONTROL  = 8'h16;
  localparam logic [7:0] ADDR_FLAG_CLEAR    = 8'h17;
  localparam logic [7:0] ADDR_DET_CTRL_ONE  = 8'h18;
  localparam logic [7:0] ADDR_DET_CTRL_TWO  = 8'h19;
  localparam logic [7:0] ADDR_LEVEL_THRESH  = 8'h1a;
  localparam logic [7:0] ADDR_PULSE_THRESH  = 8'h1b;
  localparam logic [7:0] ADDR_PULSE_DUR     = 8'h1c;
  localparam logic [7:0] ADDR_LATENCY       = 8'h1d;
  localparam logic [7:0] ADDR_SECOND_WINDOW = 8'h1e;

  // Reset value shared by every register
  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions
  localparam int Z_HIGH_W         = 3;
  localparam int MODE_LSB         = 0;
  localparam int RANGE_LSB        = 2;
  localparam int SELF_TEST_BIT    = 4;
  localparam int WIRE_COUNT_BIT   = 5;
  localparam int DATA_READY_FLAG_ROUTE_BIT   = 6;
  localparam int CLEAR_ONE_BIT    = 0;
  localparam int CLEAR_TWO_BIT    = 1;
  localparam int PIN_SWAP_BIT     = 0;
  localparam int SRC_ASSIGN_LSB   = 1;
  localparam int AXIS_DIS_LSB     = 3;
  localparam int THRESH_OPT_BIT   = 6;
  localparam int FILTER_BW_BIT    = 7;
  localparam int LEVEL_POL_BIT    = 0;
  localparam int PULSE_POL_BIT    = 1;
  localparam int DRIVE_SEL_BIT    = 2;
  localparam int SRC_FLAG_ONE_BIT = 0;
  localparam int SRC_FLAG_TWO_BIT = 1;
  localparam int SRC_PULSE_LSB    = 2;
  localparam int SRC_LEVEL_LSB    = 5;

  // Operating modes
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_MEASURE = 2'h1;
  localparam logic [1:0] MODE_LEVEL   = 2'h2;
  localparam logic [1:0] MODE_PULSE   = 2'h3;

  // Range codes
  localparam logic [1:0] RANGE_8G = 2'h0;
  localparam logic [1:0] RANGE_2G = 2'h1;
  localparam logic [1:0] RANGE_4G = 2'h2;

  // Interrupt source assignments; code 3 routes nothing
  localparam logic [1:0] SRC_LEVEL_PULSE  = 2'h0;
  localparam logic [1:0] SRC_PULSE_LEVEL  = 2'h1;
  localparam logic [1:0] SRC_SINGLE_MULTI = 2'h2;

  // Step sizes of the timing registers, in microseconds
  localparam int PULSE_DUR_STEP_US = 500;
  localparam int LATENCY_STEP_US   = 1000;
  localparam int WINDOW_STEP_US    = 1000;

endpackage

// [design/accel_motion_detect_config.sv]
// Configuration register bank and detection flag latches of a three-axis accelerometer.
// Register port is the byte access produced by the serial front end; the sensing core
// supplies per-axis threshold hits, double-pulse events and data-ready, one cycle pulses.
`timescale 1ns/1ps
module accel_motion_detect_config
  import accel_cfg_pkg::*;
#(
  parameter int AXES = 3
)(
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [2:0] level_pos_hit_i,
  input  wire logic [2:0] level_neg_hit_i,
  input  wire logic [2:0] pulse_pos_hit_i,
  input  wire logic [2:0] pulse_neg_hit_i,
  input  wire logic       double_pulse_i,
  input  wire logic       data_ready_i,
  output logic [7:0]      reg_rdata_o,
  output logic [10:0]     z_axis_trim_o,
  output logic [1:0]      op_mode_o,
  output logic [1:0]      range_select_o,
  output logic            self_test_enable_o,
  output logic            serial_wire_count_o,
  output logic            filter_bandwidth_o,
  output logic            output_drive_select_o,
  output logic            threshold_option_o,
  output logic [7:0]      level_threshold_value_o,
  output logic [6:0]      pulse_threshold_value_o,
  output logic [7:0]      pulse_duration_o,
  output logic [7:0]      latency_time_o,
  output logic [7:0]      second_pulse_window_o,
  output logic            interrupt_line_one_o,
  output logic            interrupt_line_two_o
);

  // The flag logic is written for exactly three axes
  initial
  begin
    if (AXES != 3)
      $error("accel_motion_detect_config serves exactly three axes");
  end

  // Stored registers
  logic [7:0] z_low_q;
  logic [2:0] z_high_q;
  logic [6:0] mode_ctrl_q;
  logic [1:0] clear_q;
  logic [7:0] ctrl_one_q;
  logic [2:0] ctrl_two_q;
  logic [7:0] level_thr_q;
  logic [7:0] pulse_thr_q;
  logic [7:0] pulse_dur_q;
  logic [7:0] latency_q;
  logic [7:0] window_q;

  // Latched detection flags
  logic [2:0] level_flag_q;
  logic [2:0] pulse_flag_q;
  logic       flag_one_q;
  logic       flag_two_q;

  // Write strobes, one per stored register
  wire wr_z_low     = reg_wr_i && (reg_addr_i == ADDR_Z_OFFSET_LOW);
  wire wr_z_high    = reg_wr_i && (reg_addr_i == ADDR_Z_OFFSET_HIGH);
  wire wr_mode      = reg_wr_i && (reg_addr_i == ADDR_MODE_CONTROL);
  wire wr_clear     = reg_wr_i && (reg_addr_i == ADDR_FLAG_CLEAR);
  wire wr_ctrl_one  = reg_wr_i && (reg_addr_i == ADDR_DET_CTRL_ONE);
  wire wr_ctrl_two  = reg_wr_i && (reg_addr_i == ADDR_DET_CTRL_TWO);
  wire wr_level_thr = reg_wr_i && (reg_addr_i == ADDR_LEVEL_THRESH);
  wire wr_pulse_thr = reg_wr_i && (reg_addr_i == ADDR_PULSE_THRESH);
  wire wr_pulse_dur = reg_wr_i && (reg_addr_i == ADDR_PULSE_DUR);
  wire wr_latency   = reg_wr_i && (reg_addr_i == ADDR_LATENCY);
  wire wr_window    = reg_wr_i && (reg_addr_i == ADDR_SECOND_WINDOW);

  // Configuration registers; unimplemented upper bits are dropped so they read zero, except pulse threshold bit 7, which is stored and read back
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      z_low_q     <= REG_RESET;
      z_high_q    <= REG_RESET[2:0];
      mode_ctrl_q <= REG_RESET[6:0];
      clear_q     <= REG_RESET[1:0];
      ctrl_one_q  <= REG_RESET;
      ctrl_two_q  <= REG_RESET[2:0];
      level_thr_q <= REG_RESET;
      pulse_thr_q <= REG_RESET;
      pulse_dur_q <= REG_RESET;
      latency_q   <= REG_RESET;
      window_q    <= REG_RESET;
    end
    else
    begin
      if (wr_z_low)
        z_low_q <= reg_wdata_i;
      if (wr_z_high)
        z_high_q <= reg_wdata_i[Z_HIGH_W-1:0];
      if (wr_mode)
        mode_ctrl_q <= reg_wdata_i[6:0];
      if (wr_clear)
        clear_q <= reg_wdata_i[1:0];
      if (wr_ctrl_one)
        ctrl_one_q <= reg_wdata_i;
      if (wr_ctrl_two)
        ctrl_two_q <= reg_wdata_i[2:0];
      if (wr_level_thr)
        level_thr_q <= reg_wdata_i;
      if (wr_pulse_thr)
        pulse_thr_q <= reg_wdata_i;
      if (wr_pulse_dur)
        pulse_dur_q <= reg_wdata_i;
      if (wr_latency)
        latency_q <= reg_wdata_i;
      if (wr_window)
        window_q <= reg_wdata_i;
    end
  end

  // Decoded fields
  wire [1:0] mode_f      = mode_ctrl_q[MODE_LSB+1:MODE_LSB];
  wire       data_ready_flag_off_f  = mode_ctrl_q[DATA_READY_FLAG_ROUTE_BIT];
  wire [1:0] src_f       = ctrl_one_q[SRC_ASSIGN_LSB+1:SRC_ASSIGN_LSB];
  wire       swap_f      = ctrl_one_q[PIN_SWAP_BIT];
  wire [2:0] axis_dis_f  = ctrl_one_q[AXIS_DIS_LSB+2:AXIS_DIS_LSB];
  wire       level_pol_f = ctrl_two_q[LEVEL_POL_BIT];
  wire       pulse_pol_f = ctrl_two_q[PULSE_POL_BIT];

  // Qualified per-axis hits; a disabled axis never contributes
  wire [2:0] level_axis = (level_pol_f ? level_neg_hit_i : level_pos_hit_i) & ~axis_dis_f;
  wire [2:0] pulse_axis = (pulse_pol_f ? pulse_neg_hit_i : pulse_pos_hit_i) & ~axis_dis_f;

  // Negative polarity needs every enabled axis, positive needs any one
  wire level_ev  = (mode_f == MODE_LEVEL) && (level_pol_f ?
                   (&(level_axis | axis_dis_f)) && (axis_dis_f != 3'h7) : (|level_axis));
  wire single_ev = (mode_f == MODE_PULSE) && (pulse_pol_f ?
                   (&(pulse_axis | axis_dis_f)) && (axis_dis_f != 3'h7) : (|pulse_axis));
  wire double_ev = (mode_f == MODE_PULSE) && double_pulse_i;

  // Flag two hunts doubles only when both timing windows are open
  wire double_mode = (src_f == SRC_SINGLE_MULTI) && (latency_q != 8'h00) && (window_q != 8'h00);

  // Event sources per flag and which axis group each flag owns
  logic set_one;
  logic set_two;
  logic one_is_level;
  logic two_is_level;
  logic one_is_pulse;
  logic two_is_pulse;

  // Source code 3 is undefined and leaves both flags idle
  always_comb
  begin
    set_one      = 1'b0;
    set_two      = 1'b0;
    one_is_level = 1'b0;
    two_is_level = 1'b0;
    one_is_pulse = 1'b0;
    two_is_pulse = 1'b0;
    case (src_f)
      SRC_LEVEL_PULSE:
      begin
        set_one      = level_ev;
        set_two      = single_ev;
        one_is_level = 1'b1;
        two_is_pulse = 1'b1;
      end
      SRC_PULSE_LEVEL:
      begin
        set_one      = single_ev;
        set_two      = level_ev;
        one_is_pulse = 1'b1;
        two_is_level = 1'b1;
      end
      SRC_SINGLE_MULTI:
      begin
        set_one      = single_ev;
        set_two      = double_mode ? double_ev : single_ev;
        one_is_pulse = 1'b1;
        two_is_pulse = 1'b1;
      end
      default: set_one = 1'b0;
    endcase
  end

  // Clear requests act on the write cycle only
  wire clr_one   = wr_clear && reg_wdata_i[CLEAR_ONE_BIT];
  wire clr_two   = wr_clear && reg_wdata_i[CLEAR_TWO_BIT];
  wire clr_level = (clr_one && one_is_level) || (clr_two && two_is_level);
  wire clr_pulse = (clr_one && one_is_pulse) || (clr_two && two_is_pulse);

  // Interrupt flags latch; a set in the clearing cycle wins so no event is lost
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      flag_one_q <= 1'b0;
      flag_two_q <= 1'b0;
    end
    else
    begin
      flag_one_q <= set_one || (flag_one_q && !clr_one);
      flag_two_q <= set_two || (flag_two_q && !clr_two);
    end
  end

  // Axis flags latch only with a qualified event, so a failed all-axes test leaves them clear;
  // pulse axis flags follow single pulses only, as doubles leave them meaningless
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      level_flag_q <= 3'h0;
      pulse_flag_q <= 3'h0;
    end
    else
    begin
      level_flag_q <= (level_ev ? level_axis : 3'h0)
                      | (level_flag_q & {3{!clr_level}});
      pulse_flag_q <= (single_ev ? pulse_axis : 3'h0)
                      | (pulse_flag_q & {3{!clr_pulse}});
    end
  end

  // Pin drive: pin one also carries data-ready unless routing keeps it off
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      interrupt_line_one_o <= 1'b0;
      interrupt_line_two_o <= 1'b0;
    end
    else
    begin
      interrupt_line_one_o <= (swap_f ? flag_two_q : flag_one_q)
                              || (!data_ready_flag_off_f && data_ready_i);
      interrupt_line_two_o <= swap_f ? flag_one_q : flag_two_q;
    end
  end

  // Configuration outputs, re-registered so the analogue side sees clean flops
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      z_axis_trim_o           <= 11'h000;
      op_mode_o               <= MODE_STANDBY;
      range_select_o          <= RANGE_8G;
      self_test_enable_o      <= 1'b0;
      serial_wire_count_o     <= 1'b0;
      filter_bandwidth_o      <= 1'b0;
      output_drive_select_o   <= 1'b0;
      threshold_option_o      <= 1'b0;
      level_threshold_value_o <= 8'h00;
      pulse_threshold_value_o <= 7'h00;
      pulse_duration_o        <= 8'h00;
      latency_time_o          <= 8'h00;
      second_pulse_window_o   <= 8'h00;
    end
    else
    begin
      z_axis_trim_o           <= {z_high_q, z_low_q};
      op_mode_o               <= mode_f;
      range_select_o          <= mode_ctrl_q[RANGE_LSB+1:RANGE_LSB];
      self_test_enable_o      <= mode_ctrl_q[SELF_TEST_BIT];
      serial_wire_count_o     <= mode_ctrl_q[WIRE_COUNT_BIT];
      filter_bandwidth_o      <= ctrl_one_q[FILTER_BW_BIT];
      output_drive_select_o   <= ctrl_two_q[DRIVE_SEL_BIT];
      threshold_option_o      <= ctrl_one_q[THRESH_OPT_BIT];
      // Unsigned mode ignores bit 7 in case the host forgot to keep it zero
      level_threshold_value_o <= ctrl_one_q[THRESH_OPT_BIT] ? level_thr_q
                                 : {1'b0, level_thr_q[6:0]};
      pulse_threshold_value_o <= pulse_thr_q[6:0];
      pulse_duration_o        <= pulse_dur_q;
      latency_time_o          <= latency_q;
      second_pulse_window_o   <= window_q;
    end
  end

  // Read mux; unmapped offsets answer zero
  logic [7:0] rd_mux;

  always_comb
  begin
    if (reg_addr_i == ADDR_DETECT_SOURCE)
      rd_mux = {level_flag_q[0], level_flag_q[1], level_flag_q[2],
                pulse_flag_q[0], pulse_flag_q[1], pulse_flag_q[2],
                flag_two_q, flag_one_q};
    else if (reg_addr_i == ADDR_Z_OFFSET_LOW)
      rd_mux = z_low_q;
    else if (reg_addr_i == ADDR_Z_OFFSET_HIGH)
      rd_mux = {5'h00, z_high_q};
    else if (reg_addr_i == ADDR_MODE_CONTROL)
      rd_mux = {1'b0, mode_ctrl_q};
    else if (reg_addr_i == ADDR_FLAG_CLEAR)
      rd_mux = {6'h00, clear_q};
    else if (reg_addr_i == ADDR_DET_CTRL_ONE)
      rd_mux = ctrl_one_q;
    else if (reg_addr_i == ADDR_DET_CTRL_TWO)
      rd_mux = {5'h00, ctrl_two_q};
    else if (reg_addr_i == ADDR_LEVEL_THRESH)
      rd_mux = level_thr_q;
    else if (reg_addr_i == ADDR_PULSE_THRESH)
      rd_mux = pulse_thr_q;
    else if (reg_addr_i == ADDR_PULSE_DUR)
      rd_mux = pulse_dur_q;
    else if (reg_addr_i == ADDR_LATENCY)
      rd_mux = latency_q;
    else if (reg_addr_i == ADDR_SECOND_WINDOW)
      rd_mux = window_q;
    else
      rd_mux = 8'h00;
  end

  // Read data lands one cycle after the strobe and holds until the next read
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      reg_rdata_o <= rd_mux;
  end

  // Assertions
  sequence s_clear_one_quiet;
    clr_one && !set_one;
  endsequence

  property p_clear_one;
    @(posedge clock_i) disable iff (sys_rst_i)
      s_clear_one_quiet |=> !flag_one_q;
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("flag one survived its clear");

  property p_clear_two_axes;
    @(posedge clock_i) disable iff (sys_rst_i)
      (clr_two && two_is_level && !set_two && mode_f != MODE_LEVEL) |=> (level_flag_q == 3'h0);
  endproperty
  a_clear_two_axes: assert property (p_clear_two_axes) else $error("level flags not cleared");

  property p_set_wins;
    @(posedge clock_i) disable iff (sys_rst_i)
      (set_one && clr_one) |=> flag_one_q;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost under clear");

  property p_flag_holds;
    @(posedge clock_i) disable iff (sys_rst_i)
      (flag_two_q && !clr_two) |=> flag_two_q;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag two dropped by itself");

  property p_level_mode_only;
    @(posedge clock_i) disable iff (sys_rst_i)
      (mode_f != MODE_LEVEL && src_f == SRC_LEVEL_PULSE && !flag_one_q) |=> !flag_one_q;
  endproperty
  a_level_mode_only: assert property (p_level_mode_only) else $error("level flag outside level mode");

  property p_axis_disabled;
    @(posedge clock_i) disable iff (sys_rst_i)
      (axis_dis_f[0] && !level_flag_q[0]) |=> !level_flag_q[0];
  endproperty
  a_axis_disabled: assert property (p_axis_disabled) else $error("disabled X axis flagged");

  property p_pin_routing;
    @(posedge clock_i) disable iff (sys_rst_i)
      (swap_f && $stable(swap_f)) |=> (interrupt_line_two_o == $past(flag_one_q));
  endproperty
  a_pin_routing: assert property (p_pin_routing) else $error("pin two not carrying flag one");

  property p_data_ready_flag_route;
    @(posedge clock_i) disable iff (sys_rst_i)
      (!data_ready_flag_off_f && data_ready_i) |=> interrupt_line_one_o;
  endproperty
  a_data_ready_flag_route: assert property (p_data_ready_flag_route) else $error("data-ready missing on pin one");

  sequence s_write_high;
    wr_z_high ##1 !wr_z_high ##1 (reg_rd_i && reg_addr_i == ADDR_Z_OFFSET_HIGH);
  endsequence

  property p_z_high_read;
    @(posedge clock_i) disable iff (sys_rst_i)
      s_write_high |=> (reg_rdata_o[7:3] == 5'h00) && (reg_rdata_o[2:0] == $past(reg_wdata_i[2:0], 3));
  endproperty
  a_z_high_read: assert property (p_z_high_read) else $error("z trim high reads wrong");

  property p_unsigned_thresh;
    @(posedge clock_i) disable iff (sys_rst_i)
      ##1 !$past(ctrl_one_q[THRESH_OPT_BIT]) |-> !level_threshold_value_o[7];
  endproperty
  a_unsigned_thresh: assert property (p_unsigned_thresh) else $error("unsigned threshold bit 7 set");

  property p_double_only;
    @(posedge clock_i) disable iff (sys_rst_i)
      (double_mode && !double_ev && !flag_two_q) |=> !flag_two_q;
  endproperty
  a_double_only: assert property (p_double_only) else $error("flag two set without event");

endmodule // accel_motion_detect_config

// [dv/host_model.sv]
// Host model: byte writes and reads on the bank's register port.
// Assumes the bench owns the clock; requests launch 1 ns after a rising edge.
`timescale 1ns/1ps
module host_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o
);
  initial
  begin
    {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = 18'h0;
  end
  // One strobe per byte; pulse threshold spare bit is always sent as zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    #1;
    reg_addr_o  = a;
    reg_wdata_o = (a == 8'h1b) ? {1'b0, d[6:0]} : d;
    reg_wr_o    = 1'b1;
    @(posedge clock_i);
    #1;
    reg_wr_o    = 1'b0;
    reg_wdata_o = ~reg_wdata_o; // Released data must not look valid
  endtask
  // Read data is taken once it has settled, a cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    #1;
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(posedge clock_i);
    #1;
    reg_rd_o   = 1'b0;
    @(posedge clock_i);
    #1;
    d = reg_rdata_i;
  endtask
endmodule // host_model

// [dv/testbench.sv]
// Self-checking bench for the configuration bank and its flag latches.
// Assumes the package and the bank module are compiled first.
`timescale 1ns/1ps
module testbench;
  import accel_cfg_pkg::*;
  logic        clock_i   = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [7:0]  addr, wdata, rdata, got, lth, pdur, lat, win;
  logic        wr, rd, st, wc, fbw, drv, topt, i1, i2;
  logic        dbl = 1'b0, data_ready_flag = 1'b0;
  logic [2:0]  lp = 3'h0, ln = 3'h0, pp = 3'h0, pn = 3'h0;
  logic [10:0] trim;
  logic [1:0]  mode, rng;
  logic [6:0]  pth;
  int          error_cnt = 0, check_count = 0, cycles = 0;

  always #50 clock_i = ~clock_i;

  host_model host (.clock_i(clock_i), .reg_rdata_i(rdata), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .reg_wr_o(wr), .reg_rd_o(rd));
  accel_motion_detect_config dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .level_pos_hit_i(lp), .level_neg_hit_i(ln),
    .pulse_pos_hit_i(pp), .pulse_neg_hit_i(pn), .double_pulse_i(dbl), .data_ready_i(data_ready_flag),
    .reg_rdata_o(rdata), .z_axis_trim_o(trim), .op_mode_o(mode), .range_select_o(rng),
    .self_test_enable_o(st), .serial_wire_count_o(wc), .filter_bandwidth_o(fbw),
    .output_drive_select_o(drv), .threshold_option_o(topt), .level_threshold_value_o(lth),
    .pulse_threshold_value_o(pth), .pulse_duration_o(pdur), .latency_time_o(lat),
    .second_pulse_window_o(win), .interrupt_line_one_o(i1), .interrupt_line_two_o(i2));

  task automatic stop_test();
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [10:0] s, input logic [10:0] e);
    check_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Writes wait until the field outputs have settled
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    repeat (2) @(posedge clock_i);
    #1;
  endtask
  task automatic ck(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, got);
    chk(got, e);
  endtask
  // One-cycle detection pulse, then time for flag and pin to follow
  task automatic hit(input logic [2:0] l, input logic [2:0] n, input logic [2:0] p);
    @(posedge clock_i);
    #1;
    {lp, ln, pp} = {l, n, p};
    @(posedge clock_i);
    #1;
    {lp, ln, pp} = 9'h0;
    repeat (3) @(posedge clock_i);
    #1;
  endtask
  // Pulse hits and a double-pulse event for one cycle, then time to settle
  task automatic tap(input logic [2:0] p, input logic [2:0] n, input logic d);
    @(posedge clock_i);
    #1;
    {pp, pn, dbl} = {p, n, d};
    @(posedge clock_i);
    #1;
    {pp, pn, dbl} = 7'h0;
    repeat (3) @(posedge clock_i);
    #1;
  endtask

  // Hang guard, well above the length of the sequence
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  initial
  begin
    logic [7:0] v;
    repeat (3) @(posedge clock_i);
    #1;
    sys_rst_i = 1'b0;
    for (int a = 'h14; a <= 'h1e; a++)
      ck(a[7:0], REG_RESET);
    ck(8'h3f, 8'h00);
    w(ADDR_DETECT_SOURCE, 8'hff);
    ck(ADDR_DETECT_SOURCE, 8'h00);
    // Every mode and range code, with self-test and wire count toggling
    for (int m = 0; m < 4; m++)
    begin
      v = 8'(m * 'h15);
      w(ADDR_MODE_CONTROL, v);
      chk(mode, v[1:0]);
      chk(rng, v[3:2]);
      chk({st, wc}, {v[4], v[5]});
      ck(ADDR_MODE_CONTROL, v);
    end
    w(ADDR_Z_OFFSET_LOW, 8'ha5);
    host.wr(ADDR_Z_OFFSET_HIGH, 8'hfd);
    ck(ADDR_Z_OFFSET_HIGH, 8'h05);
    chk(trim, {3'h5, 8'ha5});
    w(ADDR_PULSE_DUR, 8'hff);
    w(ADDR_LATENCY, 8'h01);
    w(ADDR_SECOND_WINDOW, 8'hff);
    w(ADDR_PULSE_THRESH, 8'hff);
    w(ADDR_DET_CTRL_TWO, 8'h04);
    chk(pdur, 8'hff);
    chk(lat, 8'h01);
    chk(win, 8'hff);
    chk({pth, drv}, {7'h7f, 1'b1});
    ck(ADDR_PULSE_THRESH, 8'h7f);
    w(ADDR_DET_CTRL_ONE, 8'hc0);
    w(ADDR_LEVEL_THRESH, 8'h85);
    chk({fbw, topt, lth}, {2'h3, 8'h85});
    w(ADDR_LEVEL_THRESH, 8'h05);
    w(ADDR_DET_CTRL_ONE, 8'h00);
    chk({fbw, topt, lth}, {2'h0, 8'h05});
    // Level detection on X lands on flag one, then clear bits
    w(ADDR_DET_CTRL_TWO, 8'h00);
    w(ADDR_MODE_CONTROL, 8'h02);
    hit(3'h1, 3'h0, 3'h0);
    chk({i1, i2}, 2'h2);
    ck(ADDR_DETECT_SOURCE, 8'h81);
    w(ADDR_FLAG_CLEAR, 8'h02);
    ck(ADDR_DETECT_SOURCE, 8'h81);
    w(ADDR_FLAG_CLEAR, 8'h01);
    w(ADDR_FLAG_CLEAR, 8'h00);
    ck(ADDR_DETECT_SOURCE, 8'h00);
    chk(i1, 1'b0);
    // An event in the clearing cycle must survive the clear
    fork
      host.wr(ADDR_FLAG_CLEAR, 8'h01);
      hit(3'h4, 3'h0, 3'h0);
    join
    ck(ADDR_DETECT_SOURCE, 8'h21);
    w(ADDR_FLAG_CLEAR, 8'h01);
    // Swapped pins, then a disabled axis
    w(ADDR_DET_CTRL_ONE, 8'h01);
    hit(3'h2, 3'h0, 3'h0);
    chk({i1, i2}, 2'h1);
    ck(ADDR_DETECT_SOURCE, 8'h41);
    w(ADDR_FLAG_CLEAR, 8'h01);
    w(ADDR_FLAG_CLEAR, 8'h00);
    w(ADDR_DET_CTRL_ONE, 8'h08);
    hit(3'h1, 3'h0, 3'h0);
    ck(ADDR_DETECT_SOURCE, 8'h00);
    // Negative level needs every axis
    w(ADDR_DET_CTRL_ONE, 8'h00);
    w(ADDR_DET_CTRL_TWO, 8'h01);
    hit(3'h0, 3'h3, 3'h0);
    ck(ADDR_DETECT_SOURCE, 8'h00);
    hit(3'h0, 3'h7, 3'h0);
    ck(ADDR_DETECT_SOURCE, 8'he1);
    w(ADDR_FLAG_CLEAR, 8'h01);
    w(ADDR_FLAG_CLEAR, 8'h00);
    // Pulse on Y lands on flag two under source 00
    w(ADDR_DET_CTRL_TWO, 8'h00);
    w(ADDR_MODE_CONTROL, 8'h03);
    hit(3'h0, 3'h0, 3'h2);
    chk({i1, i2}, 2'h1);
    ck(ADDR_DETECT_SOURCE, 8'h0a);
    w(ADDR_FLAG_CLEAR, 8'h02);
    w(ADDR_FLAG_CLEAR, 8'h00);
    ck(ADDR_DETECT_SOURCE, 8'h00);
    // Source 01: level lands on flag two, negative pulse on all axes on flag one
    w(ADDR_DET_CTRL_ONE, 8'h02);
    w(ADDR_MODE_CONTROL, 8'h02);
    hit(3'h1, 3'h0, 3'h0);
    chk({i1, i2}, 2'h1);
    w(ADDR_MODE_CONTROL, 8'h00);
    w(ADDR_FLAG_CLEAR, 8'h01);
    ck(ADDR_DETECT_SOURCE, 8'h82);
    w(ADDR_FLAG_CLEAR, 8'h02);
    ck(ADDR_DETECT_SOURCE, 8'h00);
    w(ADDR_DET_CTRL_TWO, 8'h02);
    w(ADDR_MODE_CONTROL, 8'h03);
    tap(3'h0, 3'h5, 1'b0);
    ck(ADDR_DETECT_SOURCE, 8'h00);
    tap(3'h0, 3'h7, 1'b0);
    chk({i1, i2}, 2'h2);
    ck(ADDR_DETECT_SOURCE, 8'h1d);
    w(ADDR_FLAG_CLEAR, 8'h01);
    ck(ADDR_DETECT_SOURCE, 8'h00);
    // Source 10: flag two takes only doubles while latency and window are nonzero
    w(ADDR_DET_CTRL_TWO, 8'h00);
    w(ADDR_DET_CTRL_ONE, 8'h04);
    tap(3'h1, 3'h0, 1'b0);
    ck(ADDR_DETECT_SOURCE, 8'h11);
    tap(3'h0, 3'h0, 1'b1);
    chk({i1, i2}, 2'h3);
    w(ADDR_FLAG_CLEAR, 8'h03);
    w(ADDR_SECOND_WINDOW, 8'h00);
    tap(3'h1, 3'h0, 1'b0);
    ck(ADDR_DETECT_SOURCE, 8'h13);
    w(ADDR_FLAG_CLEAR, 8'h03);
    ck(ADDR_DETECT_SOURCE, 8'h00);
    // Data-ready onto pin one only while routing bit is clear
    w(ADDR_MODE_CONTROL, 8'h00);
    data_ready_flag = 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    chk(i1, 1'b1);
    w(ADDR_MODE_CONTROL, 8'h40);
    chk(i1, 1'b0);
    data_ready_flag = 1'b0;
    stop_test();
  end
endmodule // testbench
